// ===== core/tdo_core.sv
// Option controller: APB registers, test timeout, loopback,
// stored numbers, answering and call sequence.
// Assumes pins are asynchronous levels.
`timescale 1ns/1ps
`include "tdo_params.svh"
module tdo_core
  import tdo_pkg::*;
#(
  parameter int unsigned SEC_CYCLES  = `TDO_SEC_CYC,
  parameter int unsigned STEP_CYCLES = `TDO_TR_STEP_CYC
)
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        far_end_loopback_request,
  input  wire logic        terminal_ready_lead,
  input  wire logic        net_ring,
  input  wire logic        net_wink,
  input  wire logic        net_answer,
  output logic             off_hook,
  output logic      [3:0]  dial_digit,
  output logic             dial_strobe,
  output logic             data_mode,
  output logic             test_active,
  output logic             loopback_active,
  output logic             no_wink_status,
  output logic      [7:0]  esc_guard_time
);

  // Whole register state of the block
  typedef struct packed
  {
    logic                lb_en;       // Far-end loopback accepted
    logic                aa_en;       // Auto answer
    logic                sdm;         // Switched digital mode
    logic [7:0]          test_limit;  // Test limit in seconds
    logic [7:0]          cmd_sel;     // Selected manual command
    logic [7:0]          esc_guard;   // Escape guard timer
    logic [7:0]          tr_delay;    // Ready lead delay in steps
    logic [7:0]          tr_to;       // Ready lead command timeout
    logic                cmd_ack;     // Sticky: command accepted
    logic                cmd_err;     // Sticky: command unknown
    logic                refused;     // Sticky: operation refused
    tdo_call_type        call;        // Call sequencer state
    logic                wink_seen;   // Wink received this attempt
    logic [7:0]          call_secs;   // Seconds in current call state
    logic                test_on;     // A test is running
    logic                test_remote; // Test came from the far end
    logic [7:0]          test_secs;   // Seconds in test
    tdo_digits_type      digits;      // Stored numbers
    logic [1:0][5:0]     len;         // Stored lengths
    logic                dial_sel;    // Number being dialled
    logic [5:0]          dial_idx;    // Next digit to send
    logic [3:0]          dial_digit;  // Digit on the output
    logic                dial_stb;    // Digit strobe
    logic                tr_level;    // Recognised ready lead
    logic [7:0]          tr_cnt;      // Ready lead settle count
    logic                lb_prev;     // Last loopback request level
    logic [31:0]         prdata;      // Read data
  } tdo_core_st_type;

  tdo_core_st_type q;
  tdo_core_st_type d;

  logic [4:0] pins_s;     // Synchronised pins
  logic       lb_req;     // Far-end loopback request
  logic       tr_pin;     // Ready lead level
  logic       ring;       // Incoming call
  logic       wink;       // Network wink
  logic       answer;     // Far unit answered
  logic       sec_tick;   // One-second enable
  logic       step_tick;  // 2.5 ms enable
  logic       wr;         // Write access phase
  logic       rd_setup;   // Read setup phase
  logic       mapped;     // Address decodes to a register
  logic [8:0] cmd_cur;    // {known, value} of selected command

  // Pins pass two flops before use
  tdo_sync #(.W(5)) u_sync
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     ({far_end_loopback_request, terminal_ready_lead,
               net_ring, net_wink, net_answer}),
    .dout    (pins_s)
  );

  assign {lb_req, tr_pin, ring, wink, answer} = pins_s;

  // Second timebase
  tdo_tick_div #(.DIV(SEC_CYCLES)) u_sec
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .tick    (sec_tick)
  );

  // Ready lead step timebase
  tdo_tick_div #(.DIV(STEP_CYCLES)) u_step
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .tick    (step_tick)
  );

  // Zero wait states; unmapped access fails
  assign wr       = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped   = (paddr[1:0] == 2'b00) && (paddr <= `TDO_ADDR_DIGIT);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;

  // Present value of the selected command
  always_comb
  begin
    case (q.cmd_sel)
      `TDO_CMD_TEST_LIMIT : cmd_cur = {1'b1, q.test_limit};
      `TDO_CMD_ESC_GUARD  : cmd_cur = {1'b1, q.esc_guard};  // R10
      `TDO_CMD_TR_DELAY   : cmd_cur = {1'b1, q.tr_delay};
      `TDO_CMD_TR_TIMEOUT : cmd_cur = {1'b1, q.tr_to};
      default             : cmd_cur = 9'h000;
    endcase
  end

  // Next-state logic for the whole block
  always_comb
  begin
    logic tr_rise;
    logic hang_req;
    logic ans_req;
    logic dial_req;
    logic num;
    tr_rise  = 1'b0;
    hang_req = 1'b0;
    ans_req  = 1'b0;
    dial_req = 1'b0;
    num      = pwdata[`TDO_DIGIT_NUM];
    d          = q;
    d.dial_stb = 1'b0;
    d.lb_prev  = lb_req;

    // Level taken at the tick after tr_delay full steps
    if (tr_pin == q.tr_level)
      d.tr_cnt = 8'h00;
    else if (step_tick && q.tr_cnt >= q.tr_delay)         // R8
    begin
      d.tr_level = tr_pin;
      d.tr_cnt   = 8'h00;
      tr_rise    = tr_pin;
    end
    else if (step_tick)
      d.tr_cnt = q.tr_cnt + 8'h01;                        // R8

    // Read data is prepared in the setup phase
    if (rd_setup)
    begin
      case (paddr)
        `TDO_ADDR_CTRL       : d.prdata = {29'h0, q.sdm, q.aa_en, q.lb_en};
        `TDO_ADDR_TEST_LIMIT : d.prdata = {24'h0, q.test_limit};
        `TDO_ADDR_CMD_SEL    : d.prdata = {24'h0, q.cmd_sel};
        `TDO_ADDR_CMD_VAL    : d.prdata = {23'h0, cmd_cur};     // R7
        `TDO_ADDR_STATUS     : d.prdata = {21'h0, q.refused, q.cmd_err, q.cmd_ack,
                                           q.test_remote, q.test_on, q.tr_level,
                                           ring, q.wink_seen, q.call};
        `TDO_ADDR_TEST       : d.prdata = {24'h0, q.test_secs};
        `TDO_ADDR_DIGIT      : d.prdata = {18'h0, q.len[1], 2'h0, q.len[0]};
        default              : d.prdata = 32'h0;
      endcase
    end

    // Register writes
    if (wr)
    begin
      case (paddr)
        `TDO_ADDR_CTRL :
        begin
          d.lb_en = pwdata[`TDO_CTRL_LB];
          d.aa_en = pwdata[`TDO_CTRL_AA];
          d.sdm   = pwdata[`TDO_CTRL_SDM];
        end
        `TDO_ADDR_TEST_LIMIT : d.test_limit = pwdata[7:0];      // R3
        `TDO_ADDR_CMD_SEL    : d.cmd_sel = pwdata[7:0];         // R7
        `TDO_ADDR_CMD_VAL :
        begin
          // New value or reissue, then acknowledge
          case (q.cmd_sel)
            `TDO_CMD_TEST_LIMIT : d.test_limit = pwdata[7:0];   // R3
            `TDO_CMD_ESC_GUARD  : d.esc_guard = pwdata[7:0];    // R10
            `TDO_CMD_TR_DELAY   : d.tr_delay = pwdata[7:0];     // R8
            `TDO_CMD_TR_TIMEOUT : d.tr_to = pwdata[7:0];        // R9
            default             : d.cmd_err = 1'b1;
          endcase
          if (cmd_cur[8])
            d.cmd_ack = 1'b1;                                   // R7
        end
        `TDO_ADDR_CALL :
        begin
          dial_req = pwdata[`TDO_CALL_DIAL];
          hang_req = pwdata[`TDO_CALL_HANG];
          ans_req  = pwdata[`TDO_CALL_ANSWER];
        end
        `TDO_ADDR_STATUS :
        begin
          // Write one to clear; set paths below run later and win
          if (pwdata[`TDO_ST_ACK])
            d.cmd_ack = 1'b0;
          if (pwdata[`TDO_ST_ERR])
            d.cmd_err = 1'b0;
          if (pwdata[`TDO_ST_REFUSED])
            d.refused = 1'b0;
        end
        `TDO_ADDR_TEST :
        begin
          if (pwdata[`TDO_TEST_ENTER])
          begin
            d.test_on     = 1'b1;
            d.test_remote = 1'b0;
            d.test_secs   = 8'h00;                              // R15
          end
          else if (pwdata[`TDO_TEST_EXIT])
            d.test_on = 1'b0;
        end
        `TDO_ADDR_DIGIT :
        begin
          // Start wipes the entry; digits append in order
          if (pwdata[`TDO_DIGIT_START])
            d.len[num] = 6'h00;                                 // R5
          else if (q.len[num] < 6'(`TDO_DIGITS))
          begin
            d.digits[num][q.len[num]] = pwdata[3:0];            // R5
            d.len[num] = q.len[num] + 6'h01;
          end
          else
            d.cmd_err = 1'b1;
        end
        default : ;
      endcase
    end

    // Far-end request starts or ends a remote test
    if (lb_req && !q.lb_prev && q.lb_en)                        // R4
    begin
      d.test_on     = 1'b1;
      d.test_remote = 1'b1;
      d.test_secs   = 8'h00;                                    // R15
    end
    else if (!lb_req && q.lb_prev && q.test_on && q.test_remote)
      d.test_on = 1'b0;
    else if (q.test_on && sec_tick)
    begin
      // Limit zero: runs until told to stop
      if (q.test_limit != 8'h00 &&
          q.test_secs + 8'h01 == q.test_limit)                  // R1 R2
        d.test_on = 1'b0;
      else
        d.test_secs = q.test_secs + 8'h01;                      // R15
    end

    // Call operations outside switched mode are refused
    if (!q.sdm && (dial_req || hang_req || ans_req))
      d.refused = 1'b1;                                         // R13

    // Call sequencer
    case (q.call)
      CS_IDLE :
      begin
        if (q.sdm && dial_req)
        begin
          d.call      = CS_DIAL;
          d.dial_sel  = pwdata[`TDO_CALL_SEL];
          d.dial_idx  = 6'h00;
          d.wink_seen = 1'b0;
          d.call_secs = 8'h00;
        end
        else if (q.sdm && ring && (q.aa_en || ans_req || tr_rise))
          d.call = CS_DATA;                                     // R6
        else if (q.sdm && tr_rise)
        begin
          d.call      = CS_TRWAIT;
          d.call_secs = 8'h00;
        end
      end
      CS_DIAL :
      begin
        if (wink)
          d.wink_seen = 1'b1;
        if (hang_req)
          d.call = CS_IDLE;
        else if (q.wink_seen && answer)
          d.call = CS_DATA;                                     // R12
        else if (!q.wink_seen && sec_tick &&
                 q.call_secs + 8'h01 == `TDO_WINK_WAIT_S)
        begin
          d.call      = CS_NOWINK;                              // R11
          d.call_secs = 8'h00;
        end
        else if (sec_tick)
          d.call_secs = q.call_secs + 8'h01;
        // One digit per step after the wink
        if (q.wink_seen && step_tick && q.dial_idx < q.len[q.dial_sel])
        begin
          d.dial_digit = q.digits[q.dial_sel][q.dial_idx];
          d.dial_stb   = 1'b1;
          d.dial_idx   = q.dial_idx + 6'h01;
        end
      end
      CS_NOWINK :
      begin
        if (sec_tick && q.call_secs + 8'h01 == `TDO_NOWINK_S)
          d.call = CS_IDLE;                                     // R11
        else if (sec_tick)
          d.call_secs = q.call_secs + 8'h01;
      end
      CS_TRWAIT :
      begin
        // Waits for the call the ready lead asked for
        if (hang_req)
          d.call = CS_IDLE;
        else if (ring)
          d.call = CS_DATA;
        else if (sec_tick && q.tr_to != 8'h00 &&
                 q.call_secs + 8'h01 == q.tr_to)
          d.call = CS_IDLE;                                     // R9
        else if (sec_tick)
          d.call_secs = q.call_secs + 8'h01;
      end
      CS_DATA :
      begin
        if (hang_req)
          d.call = CS_IDLE;                                     // R14
      end
      default : d.call = CS_IDLE;
    endcase

    // Leaving switched mode drops any call at once
    if (!q.sdm)
      d.call = CS_IDLE;                                         // R13
  end

  // Register the state
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      q            <= '0;
      q.lb_en      <= 1'(`TDO_CTRL_RST >> `TDO_CTRL_LB);        // R4
      q.aa_en      <= 1'(`TDO_CTRL_RST >> `TDO_CTRL_AA);        // R6
      q.test_limit <= `TDO_BYTE_RST;                            // R2
      q.call       <= CS_IDLE;
    end
    else
      q <= d;
  end

  // Outputs decode registered state
  assign prdata          = q.prdata;
  assign off_hook        = (q.call == CS_DIAL) || (q.call == CS_DATA);
  assign dial_digit      = q.dial_digit;
  assign dial_strobe     = q.dial_stb;
  assign data_mode       = (q.call == CS_DATA) && !q.test_on;
  assign test_active     = q.test_on;
  assign loopback_active = q.test_on && q.test_remote;
  assign no_wink_status  = (q.call == CS_NOWINK);
  assign esc_guard_time  = q.esc_guard;

endmodule

// ===== core/tdo_params.svh
// Controller constants: offsets, fields, resets, commands, timing.
// Assumes a 200 MHz clk_sys and byte addresses on APB.
// Summary of operation
// R1 - Test ends by itself after set timeout
// R2 - Timeout zero disables exit, zero default
// R3 - Test limit written as command 12 seconds
// R4 - Far-end loopback requests obeyed only when enabled
// R5 - Two numbers, 36 digits, whole-entry replace
// R6 - Auto answer, else command or ready lead
// R7 - Command number, show value, accept, acknowledge
// R8 - Command 19: ready lead delay, 2.5ms steps
// R9 - Command 28: ready-lead command timeout seconds
// R10 - Command 0C: escape guard timer value
// R11 - No wink: status five seconds, then idle
// R12 - Dialling holds until answer, then data
// R13 - Call operations refused outside switched mode
// R14 - Hang-up in data mode returns idle
// R15 - Test counter clears on entry, counts seconds
`ifndef TDO_PARAMS_SVH
`define TDO_PARAMS_SVH

// Register byte offsets
`define TDO_ADDR_CTRL       8'h00
`define TDO_ADDR_TEST_LIMIT 8'h04
`define TDO_ADDR_CMD_SEL    8'h08
`define TDO_ADDR_CMD_VAL    8'h0C
`define TDO_ADDR_CALL       8'h10
`define TDO_ADDR_STATUS     8'h14
`define TDO_ADDR_TEST       8'h18
`define TDO_ADDR_DIGIT      8'h1C

// Field positions
`define TDO_CTRL_LB     0
`define TDO_CTRL_AA     1
`define TDO_CTRL_SDM    2
`define TDO_CALL_DIAL   0
`define TDO_CALL_SEL    1
`define TDO_CALL_HANG   2
`define TDO_CALL_ANSWER 3
`define TDO_TEST_ENTER  0
`define TDO_TEST_EXIT   1
`define TDO_DIGIT_NUM   4
`define TDO_DIGIT_START 5
`define TDO_ST_ACK      8
`define TDO_ST_ERR      9
`define TDO_ST_REFUSED  10

// Reset values
`define TDO_CTRL_RST    3'h3
`define TDO_BYTE_RST    8'h00

// Manual command numbers
`define TDO_CMD_TEST_LIMIT 8'h12
`define TDO_CMD_ESC_GUARD  8'h0C
`define TDO_CMD_TR_DELAY   8'h19
`define TDO_CMD_TR_TIMEOUT 8'h28

// Timing
`define TDO_CLK_MHZ      200
`define TDO_TR_STEP_US   2500
`define TDO_TR_STEP_CYC  (`TDO_TR_STEP_US * `TDO_CLK_MHZ)
`define TDO_SEC_S        1
`define TDO_SEC_CYC      (`TDO_SEC_S * 1000000 * `TDO_CLK_MHZ)
`define TDO_NOWINK_S     8'h05
`define TDO_WINK_WAIT_S  8'h04
`define TDO_DIGITS       36

`endif

// ===== core/tdo_pkg.sv
// Types shared by the option controller.
// Needs no other file.
package tdo_pkg;

  // Call sequencer states
  typedef enum logic [2:0]
  {
    CS_IDLE,
    CS_DIAL,
    CS_NOWINK,
    CS_TRWAIT,
    CS_DATA
  } tdo_call_type;

  // Two stored numbers of 36 four-bit digits
  typedef logic [1:0][35:0][3:0] tdo_digits_type;

endpackage

// ===== core/tdo_sync.sv
// Two-flop synchroniser for pins from outside the clock domain.
// Assumes the inputs are quasi-static levels.
`timescale 1ns/1ps
module tdo_sync
  import tdo_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  // Both stages; the first is read only by the second
  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tdo_sync_st_type;

  tdo_sync_st_type q;
  tdo_sync_st_type d;

  // Shift the level through the two stages
  always_comb
  begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
  end

  // Register the state
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      q <= '0;
    else
      q <= d;
  end

  assign dout = q.s2;

endmodule

// ===== core/tdo_tick_div.sv
// Free-running divider giving a one-cycle enable every DIV cycles.
// Assumes DIV is at least 2.
`timescale 1ns/1ps
module tdo_tick_div
  import tdo_pkg::*;
#(
  parameter int unsigned DIV = 2
)
(
  input  wire logic clk_sys,
  input  wire logic reset,
  output logic      tick
);

  // Count and registered tick
  typedef struct packed
  {
    logic [31:0] cnt;
    logic        tick;
  } tdo_div_st_type;

  tdo_div_st_type q;
  tdo_div_st_type d;

  // Wrap at DIV-1 and pulse on the wrap
  always_comb
  begin
    d      = q;
    d.tick = 1'b0;
    if (q.cnt == 32'(DIV - 1))
    begin
      d.cnt  = 32'h0;
      d.tick = 1'b1;
    end
    else
      d.cnt = q.cnt + 32'h1;
  end

  // Register the state
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      q <= '0;
    else
      q <= d;
  end

  assign tick = q.tick;

endmodule

// ===== tb/tdo_core_chk.sv
// Port-level assertions for the option controller.
// Sees only tdo_core ports; bound below.
`timescale 1ns/1ps
module tdo_core_chk
  import tdo_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pslverr,
  input wire logic       off_hook,
  input wire logic       dial_strobe,
  input wire logic       data_mode,
  input wire logic       test_active,
  input wire logic       loopback_active,
  input wire logic       no_wink_status
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // Unmapped or misaligned address
  wire logic hole = (paddr > 8'h1C) || (paddr[1:0] != 2'h0);

  // No-wink episode ends within five seconds
  sequence s_nowink_on;
    $rose(no_wink_status);
  endsequence
  sequence s_nowink_off;
    ##[200:260] !no_wink_status;
  endsequence

  chk_hole_err: assert property (psel && penable && hole |-> pslverr)
    else $error("unmapped access not flagged");
  chk_map_ok: assert property (psel && penable && !hole |-> !pslverr)
    else $error("mapped access flagged");
  chk_nowink_end: assert property (s_nowink_on |-> s_nowink_off)
    else $error("no-wink status held too long");
  // Lasts at least four seconds
  chk_nowink_span: assert property ($fell(no_wink_status) |-> $past(no_wink_status, 200) && !off_hook)
    else $error("no-wink status too short");
  chk_nowink_idle: assert property (no_wink_status |-> !off_hook && !data_mode)
    else $error("line held during no-wink");
  chk_data_hook: assert property (data_mode |-> off_hook && !test_active)
    else $error("data mode off call or in test");
  // Strobes only while dialling, one cycle each
  chk_strobe_dial: assert property (dial_strobe |-> off_hook && !data_mode ##1 !dial_strobe)
    else $error("digit strobe outside dialling");
  chk_lb_test: assert property (loopback_active |-> test_active)
    else $error("loopback without test");
endmodule

bind tdo_core tdo_core_chk u_chk (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .paddr(paddr),
  .pslverr(pslverr), .off_hook(off_hook), .dial_strobe(dial_strobe), .data_mode(data_mode),
  .test_active(test_active), .loopback_active(loopback_active), .no_wink_status(no_wink_status)
);

// ===== tb/tdo_net_model.sv
// Switched network and far unit model.
// Winks once off hook, logs digits, answers.
`timescale 1ns/1ps
module tdo_net_model
  import tdo_pkg::*;
#(
  parameter int WINK_DLY = 20
)
(
  input  wire logic       clk_sys,
  input  wire logic       off_hook,
  input  wire logic       dial_strobe,
  input  wire logic [3:0] dial_digit,
  input  wire logic       wink_en,
  input  wire logic [5:0] ans_after,
  input  wire logic       ring_req,
  output logic            net_ring,
  output logic            net_wink,
  output logic            net_answer
);
  int         hook_cnt;  // Cycles off hook
  logic [3:0] got[$];    // Digits as dialled

  // Ring level from the bench
  assign net_ring = ring_req;

  // Four-cycle wink once off hook; answer after enough digits
  always @(posedge clk_sys)
  begin
    if (off_hook !== 1'b1)
    begin
      hook_cnt <= 0;
      net_wink <= 1'b0;
      net_answer <= 1'b0;
    end
    else
    begin
      hook_cnt <= hook_cnt + 1;
      // Outlasts the two-flop sampler
      net_wink <= wink_en && hook_cnt >= WINK_DLY && hook_cnt < WINK_DLY + 4;
      if (dial_strobe)
        got.push_back(dial_digit);
      if (got.size() >= ans_after && hook_cnt > WINK_DLY)
        net_answer <= 1'b1;
    end
  end
endmodule

// ===== tb/test_test_and_dial_option_control.sv
// Self-checking bench for the option controller.
// Drives APB and pins; short second and step.
`timescale 1ns/1ps
`include "tdo_params.svh"
module test_test_and_dial_option_control;
  import tdo_pkg::*;
  localparam int SEC = 50;  // Short second
  localparam int STP = 10;  // Short step
  localparam logic [7:0] A_CT = `TDO_ADDR_CTRL, A_TL = `TDO_ADDR_TEST_LIMIT, A_CS = `TDO_ADDR_CMD_SEL;
  localparam logic [7:0] A_CV = `TDO_ADDR_CMD_VAL, A_CA = `TDO_ADDR_CALL, A_ST = `TDO_ADDR_STATUS;
  localparam logic [7:0] A_TE = `TDO_ADDR_TEST, A_DG = `TDO_ADDR_DIGIT;

  logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr, err_seen;
  logic [7:0]  paddr, v, esc_guard_time;
  logic [31:0] pwdata, prdata, rd;
  logic        lb_req, tr_lead, ring_req, wink_en, net_ring, net_wink, net_answer;
  logic        off_hook, dial_strobe, data_mode, test_active, loopback_active, no_wink_status;
  logic [3:0]  dial_digit;
  logic [5:0]  ans_after;
  int          bad_count, total_checks, cycles, seed, n;
  int          cmd_val[4];  // Command model
  logic [7:0]  cmd_num[4] = '{`TDO_CMD_TEST_LIMIT, `TDO_CMD_ESC_GUARD, `TDO_CMD_TR_DELAY, `TDO_CMD_TR_TIMEOUT};
  logic [3:0]  exp_q[$];    // Expected digits

  tdo_core #(.SEC_CYCLES(SEC), .STEP_CYCLES(STP)) u_dut (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .far_end_loopback_request(lb_req), .terminal_ready_lead(tr_lead), .net_ring(net_ring),
    .net_wink(net_wink), .net_answer(net_answer), .off_hook(off_hook), .dial_digit(dial_digit),
    .dial_strobe(dial_strobe), .data_mode(data_mode), .test_active(test_active),
    .loopback_active(loopback_active), .no_wink_status(no_wink_status), .esc_guard_time(esc_guard_time)
  );

  tdo_net_model u_net (
    .clk_sys(clk_sys), .off_hook(off_hook), .dial_strobe(dial_strobe), .dial_digit(dial_digit),
    .wink_en(wink_en), .ans_after(ans_after), .ring_req(ring_req), .net_ring(net_ring),
    .net_wink(net_wink), .net_answer(net_answer)
  );

  // 200 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Hang guard
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits on settled falling edges; n counts
  task automatic wait_lvl(ref logic s, input logic lv, input int lim);
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (s !== lv && n < lim);
  endtask

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, lb_req, tr_lead, ring_req} = '0;
    reset = 1'b1;
    wink_en = 1'b1;
    ans_after = 6'd3;
    seed = 32'he37ae312;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    apb(0, A_CT, 0);
    chk(rd, {29'h0, `TDO_CTRL_RST});
    apb(0, A_TL, 0);
    chk(rd, 32'h0);
    apb(1, 8'h22, 32'h5);
    chk(32'(err_seen), 32'h1);
    $display("test reset ends");
    // Known commands: show, replace, acknowledge
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($random(seed));
      apb(1, A_CS, 32'(cmd_num[i]));
      apb(0, A_CV, 0);
      chk(rd, 32'h100 | cmd_val[i]);
      apb(1, A_CV, 32'(v));
      cmd_val[i] = v;
      apb(0, A_ST, 0);
      chk(32'(rd[`TDO_ST_ACK]), 32'h1);
      apb(1, A_ST, 32'h700);
      apb(0, A_CV, 0);
      chk(rd, 32'h100 | cmd_val[i]);
    end
    apb(0, A_TL, 0);
    chk(rd, cmd_val[0]);
    chk(32'(esc_guard_time), cmd_val[1]);
    apb(1, A_CS, 32'h82);
    apb(1, A_CV, 32'h1);
    apb(0, A_ST, 0);
    chk(32'(rd[`TDO_ST_ERR]), 32'h1);
    apb(1, A_ST, 32'h700);
    $display("test commands ends");
    // Exit after three seconds; zero never exits
    apb(1, A_TL, 32'h3);
    apb(1, A_TE, 32'h1);
    wait_lvl(test_active, 1'b0, 8 * SEC);
    chk(32'(n > 2 * SEC - 5 && n < 3 * SEC + 5), 32'h1);
    apb(1, A_TL, 32'h0);
    apb(1, A_TE, 32'h1);
    wait_lvl(test_active, 1'b0, 4 * SEC);
    chk(32'(test_active), 32'h1);
    apb(1, A_TE, 32'h2);
    wait_lvl(test_active, 1'b0, 4);
    chk(32'(test_active), 32'h0);
    // Far-end request obeyed only while enabled
    for (int e = 1; e >= 0; e--)
    begin
      apb(1, A_CT, 32'h2 | e);
      lb_req <= 1'b1;
      wait_lvl(loopback_active, 1'b1, 8);
      chk(32'(loopback_active), 32'(e));
      @(posedge clk_sys);
      lb_req <= 1'b0;
      wait_lvl(test_active, 1'b0, 8);
    end
    $display("test timeout ends");
    // Call operations refused outside switched mode
    for (int k = 0; k < 3; k++)
    begin
      apb(1, A_CA, 32'h1 << (k + (k > 0)));
      apb(0, A_ST, 0);
      chk(32'({rd[`TDO_ST_REFUSED], off_hook}), 32'h2);
      apb(1, A_ST, 32'h700);
    end
    // Number 1 holds 36 digits; number 0 replaced whole
    apb(1, A_CT, 32'h7);
    apb(1, A_DG, 32'h30);
    repeat (37) apb(1, A_DG, 32'h10 | ($random(seed) & 32'hF));
    apb(0, A_DG, 0);
    chk(32'(rd[13:8]), 32'd36);
    apb(0, A_ST, 0);
    chk(32'(rd[`TDO_ST_ERR]), 32'h1);
    apb(1, A_ST, 32'h700);
    for (int r = 6; r >= 3; r -= 3)
    begin
      apb(1, A_DG, 32'h20);
      exp_q.delete();
      repeat (r)
      begin
        v = 8'($random(seed) & 32'hF);
        exp_q.push_back(v[3:0]);
        apb(1, A_DG, 32'(v));
      end
    end
    apb(0, A_DG, 0);
    chk(32'(rd[5:0]), 32'd3);
    // Successful call, then hang-up
    u_net.got.delete();
    apb(1, A_CA, 32'h1);
    wait_lvl(data_mode, 1'b1, 600);
    chk(32'(data_mode), 32'h1);
    chk(u_net.got.size(), 32'd3);
    foreach (exp_q[j]) chk(32'(u_net.got[j]), 32'(exp_q[j]));
    apb(1, A_CA, 32'h4);
    wait_lvl(off_hook, 1'b0, 4);
    chk(32'({off_hook, data_mode}), 32'h0);
    // Silent network: no-wink status, then idle
    wink_en <= 1'b0;
    apb(1, A_CA, 32'h1);
    wait_lvl(no_wink_status, 1'b1, 5 * SEC);
    wait_lvl(no_wink_status, 1'b0, 6 * SEC);
    chk(32'(n > 4 * SEC - 5 && n < 5 * SEC + 5), 32'h1);
    apb(0, A_ST, 0);
    chk(32'({rd[2:0], off_hook}), 32'h0);
    wink_en <= 1'b1;
    $display("test dialling ends");
    // Answer: automatic, by command, by ready lead
    for (int m = 0; m < 3; m++)
    begin
      apb(1, A_CT, (m > 0) ? 32'h5 : 32'h7);
      apb(1, A_CS, 32'(`TDO_CMD_TR_DELAY));
      apb(1, A_CV, 32'h2);
      ring_req <= 1'b1;
      tr_lead <= (m == 2);
      wait_lvl(data_mode, 1'b1, 60);
      if (m == 1)
      begin
        chk(32'(data_mode), 32'h0);
        apb(1, A_CA, 32'h8);
        wait_lvl(data_mode, 1'b1, 6);
      end
      chk(32'(data_mode), 32'h1);
      if (m == 2)
        chk(32'(n >= 2 * STP && n <= 4 * STP), 32'h1);
      @(posedge clk_sys);
      ring_req <= 1'b0;
      tr_lead <= 1'b0;
      repeat (4) @(posedge clk_sys);
      apb(1, A_CA, 32'h4);
      wait_lvl(data_mode, 1'b0, 4);
    end
    $display("test answering ends");
    close_out();
  end
endmodule
